// ---- hdl/ama_alarm_mask_aggregator.sv ----
// alarm masking and summary logic with an apb register slave
`timescale 1ns/10ps
`default_nettype none
`include "ama_map.svh"
module ama_alarm_mask_aggregator (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// alarm sources
	input wire ama_pkg::ama_src_t src,
	// summary alarm
	output logic alarm
);
	ama_pkg::ama_state_t state;
	ama_pkg::ama_state_t next_state;
	logic [4:0] src_vec;
	logic [4:0] clr;
	logic [4:0] flags_now;
	logic [4:0] mask_now;
	logic [4:0] gated;
	logic setup;
	logic acc_done;
	logic hit_sum;
	logic hit_flags;
	logic hit_mask;

	assign src_vec = src;
	assign setup = psel && !penable;
	assign hit_sum = paddr[13:0] == `AMA_ADDR_SUMMARY;
	assign hit_flags = paddr[13:0] == `AMA_ADDR_FLAGS;
	assign hit_mask = paddr[13:0] == `AMA_ADDR_MASK;
	assign flags_now = state.alarm_sticky_flags;
	assign mask_now = state.alarm_source_mask;
	// completing edge of any transfer, read only by the checks
	assign acc_done = psel && penable && pready;

	always_comb begin
		next_state = state;
		clr = 5'h00;
		next_state.pready = 1'b0;
		next_state.pslverr = 1'b0;
		// answer one cycle after setup: access phase sees pready high
		if (setup) begin
			next_state.pready = 1'b1;
			next_state.pslverr = !(hit_sum || hit_flags || hit_mask) || (paddr[31:14] != 18'h00000);
			next_state.prdata = 32'h00000000;
			if (!pwrite) begin
				if (hit_sum)
					next_state.prdata = {31'h00000000, state.summary};
				else if (hit_flags)
					next_state.prdata = {27'h0000000, state.alarm_sticky_flags};
				else if (hit_mask)
					next_state.prdata = {27'h0000000, state.alarm_source_mask};
			end
		end
		// writes take effect at the completing edge, when pready is already high
		if (psel && penable && state.pready && pwrite && pstrb[0] && !state.pslverr) begin
			if (hit_mask)
				next_state.alarm_source_mask = pwdata[4:0];
			if (hit_flags)
				clr = pwdata[4:0];
		end
		// set wins over a write-one clear issued in the same cycle
		next_state.alarm_sticky_flags = (state.alarm_sticky_flags & ~clr) | src_vec;
		// summary follows registered flags and mask, one cycle behind them
		next_state.summary = |gated;
	end

	// one gate per source; a set mask bit keeps its flag out of the summary
	for (genvar g = 0; g < `AMA_NUM_SRC; g++) begin : gate_gen
		assign gated[g] = flags_now[g] && !mask_now[g];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state.alarm_source_mask <= `AMA_MASK_RESET;
			state.alarm_sticky_flags <= `AMA_FLAGS_RESET;
			state.summary <= 1'b0;
			state.pready <= 1'b0;
			state.pslverr <= 1'b0;
			state.prdata <= 32'h00000000;
		end else begin
			state <= next_state;
		end
	end

	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign prdata = state.prdata;
	assign alarm = state.summary;

	a_pll_mask_gate: assert property (@(posedge clk) disable iff (rst)
		(state.alarm_source_mask[`AMA_BIT_PLL] && state.alarm_sticky_flags[4:0] == 5'h10)
		|=> !alarm) else $error("masked pll flag reached summary");
	a_realign_mask_gate: assert property (@(posedge clk) disable iff (rst)
		(state.alarm_source_mask[`AMA_BIT_REALIGN] && state.alarm_sticky_flags == 5'h04)
		|=> !alarm) else $error("masked realign flag reached summary");
	a_osc_mask_gate: assert property (@(posedge clk) disable iff (rst)
		(state.alarm_source_mask[`AMA_BIT_OSC] && state.alarm_sticky_flags == 5'h02)
		|=> !alarm) else $error("masked oscillator flag reached summary");
	a_divider_mask_gate: assert property (@(posedge clk) disable iff (rst)
		(state.alarm_source_mask[`AMA_BIT_DIVIDER] && state.alarm_sticky_flags == 5'h01)
		|=> !alarm) else $error("masked divider flag reached summary");
	a_mask_reset_value: assert property (@(posedge clk)
		(!rst && $past(rst)) |-> state.alarm_source_mask == 5'h1F)
		else $error("mask reset value wrong");
	a_link_mask_gate: assert property (@(posedge clk) disable iff (rst)
		(state.alarm_source_mask[`AMA_BIT_LINK] && state.alarm_sticky_flags == 5'h08)
		|=> !alarm) else $error("masked link flag reached summary");
	a_summary_unmasked: assert property (@(posedge clk) disable iff (rst)
		|(state.alarm_sticky_flags & ~state.alarm_source_mask) |=> alarm)
		else $error("unmasked flag missing from summary");
	a_pll_flag_sticky: assert property (@(posedge clk) disable iff (rst)
		src.pll_unlock |=> state.alarm_sticky_flags[`AMA_BIT_PLL])
		else $error("pll unlock flag not set");
	a_link_flag_sticky: assert property (@(posedge clk) disable iff (rst)
		(state.alarm_sticky_flags[`AMA_BIT_LINK] && !(psel && penable && pwrite && hit_flags))
		|=> state.alarm_sticky_flags[`AMA_BIT_LINK]) else $error("link flag dropped without clear");
	a_realign_flag_set: assert property (@(posedge clk) disable iff (rst)
		src.realign |=> state.alarm_sticky_flags[`AMA_BIT_REALIGN])
		else $error("realign flag not set");
	a_apb_answer: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable) |=> pready) else $error("apb answer late");
	a_pready_single: assert property (@(posedge clk) disable iff (rst)
		pready |=> !pready) else $error("pready held too long");
	a_err_with_ready: assert property (@(posedge clk) disable iff (rst)
		pslverr |-> pready) else $error("pslverr without pready");
	a_bad_addr_err: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable && paddr[31:14] != 18'h00000) |=> pslverr)
		else $error("upper address bits not refused");
	a_unmapped_read_zero: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable && !pwrite && !(hit_sum || hit_flags || hit_mask)) |=> prdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_read_mask_data: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable && !pwrite && hit_mask && paddr[31:14] == 18'h00000)
		|=> prdata == {27'h0000000, $past(state.alarm_source_mask)})
		else $error("mask read data wrong");
	a_read_flags_data: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable && !pwrite && hit_flags && paddr[31:14] == 18'h00000)
		|=> prdata == {27'h0000000, $past(state.alarm_sticky_flags)})
		else $error("flags read data wrong");
	a_read_summary_data: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable && !pwrite && hit_sum && paddr[31:14] == 18'h00000)
		|=> prdata == {31'h00000000, $past(alarm)})
		else $error("summary read data wrong");

	// flag setting, holding and clearing
	a_link_flag_set: assert property (@(posedge clk) disable iff (rst)
		src.link_down |=> state.alarm_sticky_flags[`AMA_BIT_LINK])
		else $error("link flag not set");
	a_osc_flag_set: assert property (@(posedge clk) disable iff (rst)
		src.osc_phase |=> state.alarm_sticky_flags[`AMA_BIT_OSC])
		else $error("oscillator flag not set");
	a_divider_flag_set: assert property (@(posedge clk) disable iff (rst)
		src.divider_mismatch |=> state.alarm_sticky_flags[`AMA_BIT_DIVIDER])
		else $error("divider flag not set");
	a_pll_flag_hold: assert property (@(posedge clk) disable iff (rst)
		(state.alarm_sticky_flags[`AMA_BIT_PLL] && !(acc_done && pwrite && hit_flags))
		|=> state.alarm_sticky_flags[`AMA_BIT_PLL]) else $error("pll flag dropped without clear");
	a_realign_flag_hold: assert property (@(posedge clk) disable iff (rst)
		(state.alarm_sticky_flags[`AMA_BIT_REALIGN] && !(acc_done && pwrite && hit_flags))
		|=> state.alarm_sticky_flags[`AMA_BIT_REALIGN]) else $error("realign flag dropped");
	a_osc_flag_hold: assert property (@(posedge clk) disable iff (rst)
		(state.alarm_sticky_flags[`AMA_BIT_OSC] && !(acc_done && pwrite && hit_flags))
		|=> state.alarm_sticky_flags[`AMA_BIT_OSC]) else $error("oscillator flag dropped");
	a_divider_flag_hold: assert property (@(posedge clk) disable iff (rst)
		(state.alarm_sticky_flags[`AMA_BIT_DIVIDER] && !(acc_done && pwrite && hit_flags))
		|=> state.alarm_sticky_flags[`AMA_BIT_DIVIDER]) else $error("divider flag dropped");
	a_pll_flag_clear: assert property (@(posedge clk) disable iff (rst)
		(acc_done && pwrite && pstrb[0] && hit_flags && paddr[31:14] == 18'h00000
			&& pwdata[`AMA_BIT_PLL] && !src.pll_unlock)
		|=> !state.alarm_sticky_flags[`AMA_BIT_PLL]) else $error("pll flag not cleared");
	a_link_flag_clear: assert property (@(posedge clk) disable iff (rst)
		(acc_done && pwrite && pstrb[0] && hit_flags && paddr[31:14] == 18'h00000
			&& pwdata[`AMA_BIT_LINK] && !src.link_down)
		|=> !state.alarm_sticky_flags[`AMA_BIT_LINK]) else $error("link flag not cleared");
	a_realign_flag_clear: assert property (@(posedge clk) disable iff (rst)
		(acc_done && pwrite && pstrb[0] && hit_flags && paddr[31:14] == 18'h00000
			&& pwdata[`AMA_BIT_REALIGN] && !src.realign)
		|=> !state.alarm_sticky_flags[`AMA_BIT_REALIGN]) else $error("realign flag not cleared");
	a_flags_reset_value: assert property (@(posedge clk)
		(!rst && $past(rst)) |-> state.alarm_sticky_flags == `AMA_FLAGS_RESET)
		else $error("flags reset value wrong");

	// mask register and summary
	a_mask_write_lands: assert property (@(posedge clk) disable iff (rst)
		(acc_done && pwrite && pstrb[0] && hit_mask && paddr[31:14] == 18'h00000)
		|=> state.alarm_source_mask == $past(pwdata[4:0])) else $error("mask write lost");
	a_mask_strobe_off: assert property (@(posedge clk) disable iff (rst)
		(acc_done && pwrite && !pstrb[0]) |=> $stable(state.alarm_source_mask))
		else $error("mask changed without strobe");
	a_summary_quiet: assert property (@(posedge clk) disable iff (rst)
		!(|(state.alarm_sticky_flags & ~state.alarm_source_mask)) |=> !alarm)
		else $error("summary set with every flag masked");
	a_summary_after_reset: assert property (@(posedge clk)
		(!rst && $past(rst)) |-> !alarm) else $error("summary not clear after reset");

	c_summary_rise: cover property (@(posedge clk) disable iff (rst) !alarm ##1 alarm);
	c_flag_clear: cover property (@(posedge clk) disable iff (rst)
		state.alarm_sticky_flags[`AMA_BIT_PLL] ##1 !state.alarm_sticky_flags[`AMA_BIT_PLL]);
	c_mask_write: cover property (@(posedge clk) disable iff (rst)
		psel && penable && pready && pwrite && hit_mask);
	c_bad_addr: cover property (@(posedge clk) disable iff (rst) pready && pslverr);
	c_set_wins: cover property (@(posedge clk) disable iff (rst)
		acc_done && pwrite && hit_flags && pwdata[`AMA_BIT_PLL] && src.pll_unlock);
endmodule : ama_alarm_mask_aggregator
`default_nettype wire

// ---- pkg/ama_map.svh ----
// register offsets, field positions and reset values of the alarm mask aggregator
`ifndef AMA_MAP_SVH
`define AMA_MAP_SVH
`define AMA_IDX_SUMMARY 12'h2C0
`define AMA_IDX_FLAGS 12'h2C1
`define AMA_IDX_MASK 12'h2C2
`define AMA_ADDR_SUMMARY 14'h0B00
`define AMA_ADDR_FLAGS 14'h0B04
`define AMA_ADDR_MASK 14'h0B08
`define AMA_BIT_DIVIDER 0
`define AMA_BIT_OSC 1
`define AMA_BIT_REALIGN 2
`define AMA_BIT_LINK 3
`define AMA_BIT_PLL 4
`define AMA_NUM_SRC 5
`define AMA_MASK_RESET 5'h1F
`define AMA_FLAGS_RESET 5'h1F
`endif

// ---- pkg/ama_pkg.sv ----
// types of the alarm mask aggregator
`default_nettype none
package ama_pkg;
	typedef struct packed {
		logic pll_unlock;
		logic link_down;
		logic realign;
		logic osc_phase;
		logic divider_mismatch;
	} ama_src_t;
	typedef struct packed {
		logic [4:0] alarm_source_mask;
		logic [4:0] alarm_sticky_flags;
		logic summary;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ama_state_t;
endpackage : ama_pkg
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking apb testbench of the alarm mask aggregator
`timescale 1ns/10ps
`default_nettype none
`include "ama_map.svh"
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	ama_pkg::ama_src_t src = '0;
	logic alarm;
	logic [31:0] rd;
	logic err;
	logic [17:0] addr_hi = 18'h00000;
	int n_errors = 0;
	int check_count = 0;
	ama_alarm_mask_aggregator ama_alarm_mask_aggregator_inst (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .src(src), .alarm(alarm));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// request held until pready is seen high at a rising edge; data taken at that edge
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {addr_hi, a};
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (2000) @(posedge clk);
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `AMA_ADDR_MASK, 32'h0, 4'hF);
		chk("mask reset", rd, 32'h1F);
		apb(1'b0, `AMA_ADDR_FLAGS, 32'h0, 4'hF);
		chk("flags reset", rd, 32'h1F);
		apb(1'b0, `AMA_ADDR_SUMMARY, 32'h0, 4'hF);
		chk("summary all masked", rd, 32'h0);
		apb(1'b1, `AMA_ADDR_MASK, 32'hFF, 4'hF);
		apb(1'b0, `AMA_ADDR_MASK, 32'h0, 4'hF);
		chk("mask reserved", rd, 32'h1F);
		apb(1'b1, `AMA_ADDR_MASK, 32'h0, 4'hE);
		apb(1'b0, 14'h0B0C, 32'h0, 4'hF);
		chk("unmapped err", {31'h0, err}, 32'h1);
		apb(1'b1, 14'h0B0C, 32'h0, 4'hF);
		chk("unmapped write err", {31'h0, err}, 32'h1);
		addr_hi = 18'h00001;
		apb(1'b1, `AMA_ADDR_MASK, 32'h0, 4'hF);
		addr_hi = 18'h00000;
		chk("upper address err", {31'h0, err}, 32'h1);
		apb(1'b1, `AMA_ADDR_SUMMARY, 32'hFFFFFFFF, 4'hF);
		chk("summary write no err", {31'h0, err}, 32'h0);
		apb(1'b0, `AMA_ADDR_MASK, 32'h0, 4'hF);
		chk("mask no strobe", rd, 32'h1F);
		$display("test reset and refusal done");
		apb(1'b1, `AMA_ADDR_FLAGS, 32'h1F, 4'hF);
		// each source alone, unmasked then masked
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `AMA_ADDR_MASK, 32'h1F ^ (32'h1 << i), 4'hF);
			@(posedge clk);
			src <= 5'h1 << i;
			@(posedge clk);
			src <= '0;
			apb(1'b0, `AMA_ADDR_FLAGS, 32'h0, 4'hF);
			chk("sticky flag", rd, 32'h1 << i);
			apb(1'b0, `AMA_ADDR_SUMMARY, 32'h0, 4'hF);
			chk("summary unmasked", rd, 32'h1);
			chk("alarm unmasked", {31'h0, alarm}, 32'h1);
			apb(1'b1, `AMA_ADDR_MASK, 32'h1F, 4'hF);
			apb(1'b0, `AMA_ADDR_SUMMARY, 32'h0, 4'hF);
			chk("summary masked", rd, 32'h0);
			chk("alarm masked", {31'h0, alarm}, 32'h0);
			apb(1'b1, `AMA_ADDR_FLAGS, 32'h1 << i, 4'hF);
			apb(1'b0, `AMA_ADDR_FLAGS, 32'h0, 4'hF);
			chk("flag cleared", rd, 32'h0);
		end
		$display("test per source done");
		src <= 5'h10;
		apb(1'b1, `AMA_ADDR_FLAGS, 32'h1F, 4'hF);
		apb(1'b0, `AMA_ADDR_FLAGS, 32'h0, 4'hF);
		chk("set wins", rd, 32'h10);
		$display("test set wins done");
		apb(1'b1, `AMA_ADDR_MASK, 32'h0, 4'hF);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `AMA_ADDR_MASK, 32'h0, 4'hF);
		chk("mask after reset", rd, 32'h1F);
		chk("alarm after reset", {31'h0, alarm}, 32'h0);
		apb(1'b0, `AMA_ADDR_FLAGS, 32'h0, 4'hF);
		chk("flags after reset", rd, 32'h1F);
		$display("test reset in mid run done");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
